/* File: design/timer_pkg.sv */
// timer_pkg: shared constants, register map and carrier types of the timer block
// assumes one clock domain and a classic wishbone master with 32-bit data
//
// Summary of operation
// - a three-bit select picks full or divided system, divided high, timebase or external clock
// - the reserved select code feeds no clock, so the counter stops
// - counter equal to a comparator raises an event, may clear counter, drive pin
// - each timer has two interrupt sources, comparator A and comparator P
// - the external clock pin drives the counter only when selected
// - software picks rising or falling external clock edge
// - compare match output mode sets, clears or toggles the output pin
// - pwm mode emits the waveform on the timer output pin
// - capture input mode treats the timer pin as an input on timer 1 only; timer 0 has no capture and leaves its pin alone
// - run, mode and pin control settings decide pin use; otherwise other functions own it
// - pin control bit 1 assigns timer 1 pin, bit 0 timer 0 pin
// - two timers: timer 0 compact type, timer 1 standard type
// - 16-bit up counter cleared by run rising, overflow or compare match
package timer_pkg;

  // ----------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int CMPP_W = 8;
  localparam int NUM_TIMERS = 2;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_CTRL_OFS = 8'h00;
  localparam logic [7:0] INT_STATUS_OFS = 8'h04;
  localparam logic [7:0] INT_MASK_OFS = 8'h08;
  // timer n occupies page n+1, page held in address bits 7:5
  localparam logic [2:0] TIMER0_PAGE = 3'h1;
  localparam logic [2:0] TIMER1_PAGE = 3'h2;
  localparam logic [4:0] CTRL_SUB = 5'h00;
  localparam logic [4:0] CMPA_SUB = 5'h04;
  localparam logic [4:0] CMPP_SUB = 5'h08;
  localparam logic [4:0] COUNT_SUB = 5'h0c;
  localparam logic [4:0] CAPTURE_SUB = 5'h10;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PIN_CTRL_RST = 2'h0;
  localparam logic [3:0] INT_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // clock select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CLK_SYS = 3'h1;
  localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CLK_TIMEBASE = 3'h4;
  localparam logic [2:0] CLK_RESERVED = 3'h5;
  localparam logic [2:0] CLK_EXT_A = 3'h6;
  localparam logic [2:0] CLK_EXT_B = 3'h7;

  // prescaler masks: tick when masked prescaler bits are all zero
  localparam int PRESCALE_W = 6;
  localparam logic [5:0] DIV4_MASK = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0f;
  localparam logic [5:0] DIV64_MASK = 6'h3f;

  // ----------------------------------------------------------------
  // operating modes and output actions
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // control word of one timer, bit 0 is run
  typedef struct packed {
    logic clearOnA;
    logic extFalling;
    logic polarity;
    logic [1:0] outAction;
    logic [1:0] mode;
    logic pause;
    logic [2:0] clkSel;
    logic run;
  } timer_cfg_t;

  localparam int CFG_W = 12;
  localparam logic [CFG_W-1:0] CFG_RST = 12'h000;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] dat;
  } wb_rsp_t;

endpackage : timer_pkg

/* File: design/timer_unit.sv */
// timer_unit: one 16-bit timer with comparators A and P and its pin logic
// assumes a one-cycle count tick from the owning block, and an asynchronous pin input
module timer_unit #(
  parameter bit HAS_CAPTURE = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // configuration
  input wire timer_pkg::timer_cfg_t cfg,
  input wire logic [15:0] cmpA,
  input wire logic [7:0] cmpP,
  input wire logic pinEnable,
  input wire logic countTick,
  // status
  output logic [15:0] count,
  output logic [15:0] capture,
  output logic matchA,
  output logic matchP,
  // pin
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic pinInUse
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] capVal;
    logic runLast;
    logic pinLevel;
    logic pinS1;
    logic pinS2;
    logic pinLast;
    logic evA;
    logic evP;
  } unit_state_t;

  unit_state_t r;
  unit_state_t nxt;
  logic capMode;
  logic running;
  logic hitA;
  logic hitP;

  assign capMode = HAS_CAPTURE && (cfg.mode == timer_pkg::MODE_CAPTURE);
  assign running = cfg.run && r.runLast && !cfg.pause;
  assign hitA = !capMode && (r.cnt == cmpA);
  assign hitP = (r.cnt[15:8] == cmpP) && (r.cnt[7:0] == 8'h00);

  always_comb
  begin
    nxt = r;
    nxt.evA = 1'b0;
    nxt.evP = 1'b0;
    nxt.runLast = cfg.run;
    nxt.pinS1 = pinIn;
    nxt.pinS2 = r.pinS1;
    nxt.pinLast = r.pinS2;
    if (cfg.run && !r.runLast)
    begin
      nxt.cnt = 16'h0000;
    end
    else if (running && countTick)
    begin
      nxt.evA = hitA;
      nxt.evP = hitP;
      if ((cfg.clearOnA ? hitA : hitP) || (r.cnt == 16'hffff))
      begin
        nxt.cnt = 16'h0000;
      end
      else
      begin
        nxt.cnt = r.cnt + 16'h0001;
      end
      if (cfg.mode == timer_pkg::MODE_COMPARE && hitA)
      begin
        case (cfg.outAction)
          timer_pkg::ACT_LOW: nxt.pinLevel = 1'b0;
          timer_pkg::ACT_HIGH: nxt.pinLevel = 1'b1;
          timer_pkg::ACT_TOGGLE: nxt.pinLevel = !r.pinLevel;
          default: nxt.pinLevel = r.pinLevel;
        endcase
      end
    end
    if (cfg.mode == timer_pkg::MODE_PWM)
    begin
      nxt.pinLevel = (r.cnt < cmpA);
    end
    if (capMode && cfg.run && r.pinS2 && !r.pinLast)
    begin
      nxt.capVal = r.cnt;
      nxt.evA = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      r <= '0;
    end
    else
    begin
      r <= nxt;
    end
  end

  assign count = r.cnt;
  assign capture = r.capVal;
  assign matchA = r.evA;
  assign matchP = r.evP;
  assign pinOut = r.pinLevel ^ cfg.polarity;
  // pin use from run, mode and enable
  assign pinInUse = pinEnable && cfg.run && (cfg.mode != timer_pkg::MODE_TIMER)
    && (HAS_CAPTURE || cfg.mode != timer_pkg::MODE_CAPTURE);
  assign pinOe = pinInUse && !capMode;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence seqRunRise;
    !cfg.run ##1 cfg.run;
  endsequence

  chk_run_clear: assert property (seqRunRise |=> r.cnt == 16'h0000)
    else $error("counter not cleared after run rose");
  chk_count_step: assert property (
    (running && countTick && !(cfg.clearOnA ? hitA : hitP) && r.cnt != 16'hffff)
    |=> r.cnt == $past(r.cnt) + 16'h0001)
    else $error("counter did not step by one on a tick");
  chk_match_event: assert property ((running && countTick && hitA) |=> r.evA)
    else $error("comparator A match gave no event");
  chk_toggle_action: assert property (
    (running && countTick && hitA && cfg.mode == timer_pkg::MODE_COMPARE
    && cfg.outAction == timer_pkg::ACT_TOGGLE) |=> r.pinLevel != $past(r.pinLevel))
    else $error("toggle action did not toggle the pin");
  chk_pwm_wave: assert property (
    cfg.mode == timer_pkg::MODE_PWM |=> r.pinLevel == ($past(r.cnt) < $past(cmpA)))
    else $error("pwm level does not follow counter compare");
  chk_capture_input: assert property (capMode |-> !pinOe)
    else $error("pin driven in capture mode");

endmodule : timer_unit

/* File: design/timer_block.sv */
// timer_block: two timers, pin function control and interrupt logic behind wishbone
// assumes a classic wishbone master on ref_clk; pins arrive asynchronously
module timer_block (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register bus
  input wire timer_pkg::wb_req_t wbReq,
  output timer_pkg::wb_rsp_t wbRsp,
  // clock sources
  input wire logic timebaseClk,
  input wire logic [1:0] extClkPin,
  output logic [1:0] extClkInUse,
  // timer pins
  input wire logic [1:0] timerPinIn,
  output logic [1:0] timerPinOut,
  output logic [1:0] timerPinOe,
  output logic [1:0] timerPinInUse,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pinCtrl;
    logic [3:0] intStatus;
    logic [3:0] intMask;
    logic [1:0][11:0] cfg;
    logic [1:0][15:0] cmpA;
    logic [1:0][7:0] cmpP;
    logic [5:0] prescale;
    logic [1:0] extS1;
    logic [1:0] extS2;
    logic [1:0] extLast;
    logic tbS1;
    logic tbS2;
    logic tbLast;
    logic ack;
    logic [31:0] rdData;
  } top_state_t;

  top_state_t r;
  top_state_t nxt;
  timer_pkg::timer_cfg_t cfgT [2];
  logic [1:0] tick;
  logic [1:0] extTick;
  logic tbTick;
  logic [1:0][15:0] count;
  logic [1:0][15:0] capture;
  logic [3:0] events;
  logic busReq;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] laneMask(input logic [3:0] sel);
    laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : laneMask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
    input logic [3:0] sel);
    merge = (old & ~laneMask(sel)) | (din & laneMask(sel));
  endfunction : merge

  function automatic logic [5:0] divMask(input logic [2:0] sel);
    case (sel)
      timer_pkg::CLK_SYS_DIV4: divMask = timer_pkg::DIV4_MASK;
      timer_pkg::CLK_HIGH_DIV16: divMask = timer_pkg::DIV16_MASK;
      timer_pkg::CLK_HIGH_DIV64: divMask = timer_pkg::DIV64_MASK;
      default: divMask = 6'h00;
    endcase
  endfunction : divMask

  function automatic logic isExt(input logic [2:0] sel);
    isExt = (sel == timer_pkg::CLK_EXT_A) || (sel == timer_pkg::CLK_EXT_B);
  endfunction : isExt

  function automatic logic [2:0] pageOf(input int n);
    pageOf = (n == 0) ? timer_pkg::TIMER0_PAGE : timer_pkg::TIMER1_PAGE;
  endfunction : pageOf

  // ----------------------------------------------------------------
  // clock selection
  // ----------------------------------------------------------------
  assign tbTick = r.tbS2 && !r.tbLast;

  always_comb
  begin
    for (int n = 0; n < timer_pkg::NUM_TIMERS; n++)
    begin
      cfgT[n] = timer_pkg::timer_cfg_t'(r.cfg[n]);
      extTick[n] = cfgT[n].extFalling ? (!r.extS2[n] && r.extLast[n])
        : (r.extS2[n] && !r.extLast[n]);
      // pin is a clock only when selected
      extClkInUse[n] = isExt(cfgT[n].clkSel);
      case (cfgT[n].clkSel)
        timer_pkg::CLK_SYS: tick[n] = 1'b1;
        timer_pkg::CLK_SYS_DIV4,
        timer_pkg::CLK_HIGH_DIV16,
        timer_pkg::CLK_HIGH_DIV64: tick[n] = (r.prescale & divMask(cfgT[n].clkSel)) == 6'h00;
        timer_pkg::CLK_TIMEBASE: tick[n] = tbTick;
        timer_pkg::CLK_EXT_A,
        timer_pkg::CLK_EXT_B: tick[n] = extTick[n];
        default: tick[n] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  // timer 0 compact, timer 1 standard
  timer_unit #(
    .HAS_CAPTURE(1'b0)
  ) timer0 (
    .ref_clk(ref_clk),
    .reset(reset),
    .cfg(cfgT[0]),
    .cmpA(r.cmpA[0]),
    .cmpP(r.cmpP[0]),
    .pinEnable(r.pinCtrl[0]),
    .countTick(tick[0]),
    .count(count[0]),
    .capture(capture[0]),
    .matchA(events[0]),
    .matchP(events[1]),
    .pinIn(timerPinIn[0]),
    .pinOut(timerPinOut[0]),
    .pinOe(timerPinOe[0]),
    .pinInUse(timerPinInUse[0])
  );

  timer_unit #(
    .HAS_CAPTURE(1'b1)
  ) timer1 (
    .ref_clk(ref_clk),
    .reset(reset),
    .cfg(cfgT[1]),
    .cmpA(r.cmpA[1]),
    .cmpP(r.cmpP[1]),
    .pinEnable(r.pinCtrl[1]),
    .countTick(tick[1]),
    .count(count[1]),
    .capture(capture[1]),
    .matchA(events[2]),
    .matchP(events[3]),
    .pinIn(timerPinIn[1]),
    .pinOut(timerPinOut[1]),
    .pinOe(timerPinOe[1]),
    .pinInUse(timerPinInUse[1])
  );

  // ----------------------------------------------------------------
  // next state: synchronisers, bus slave, interrupts
  // ----------------------------------------------------------------
  assign busReq = wbReq.cyc && wbReq.stb && !r.ack;

  always_comb
  begin
    logic [31:0] w1c;
    w1c = 32'h0000_0000;
    nxt = r;
    nxt.prescale = r.prescale + 6'h01;
    nxt.extS1 = extClkPin;
    nxt.extS2 = r.extS1;
    nxt.extLast = r.extS2;
    nxt.tbS1 = timebaseClk;
    nxt.tbS2 = r.tbS1;
    nxt.tbLast = r.tbS2;
    nxt.ack = busReq;
    nxt.rdData = 32'h0000_0000;
    if (busReq && wbReq.we)
    begin
      case (wbReq.adr)
        timer_pkg::PIN_CTRL_OFS:
          nxt.pinCtrl = 2'(merge(32'(r.pinCtrl), wbReq.dat, wbReq.sel));
        timer_pkg::INT_STATUS_OFS:
          w1c = wbReq.dat & laneMask(wbReq.sel);
        timer_pkg::INT_MASK_OFS:
          nxt.intMask = 4'(merge(32'(r.intMask), wbReq.dat, wbReq.sel));
        default:
        begin
          for (int n = 0; n < timer_pkg::NUM_TIMERS; n++)
          begin
            if (wbReq.adr[7:5] == pageOf(n))
            begin
              case (wbReq.adr[4:0])
                timer_pkg::CTRL_SUB:
                  nxt.cfg[n] = 12'(merge(32'(r.cfg[n]), wbReq.dat, wbReq.sel));
                timer_pkg::CMPA_SUB:
                  nxt.cmpA[n] = 16'(merge(32'(r.cmpA[n]), wbReq.dat, wbReq.sel));
                timer_pkg::CMPP_SUB:
                  nxt.cmpP[n] = 8'(merge(32'(r.cmpP[n]), wbReq.dat, wbReq.sel));
                default: ;
              endcase
            end
          end
        end
      endcase
    end
    else if (busReq)
    begin
      case (wbReq.adr)
        timer_pkg::PIN_CTRL_OFS: nxt.rdData = 32'(r.pinCtrl);
        timer_pkg::INT_STATUS_OFS: nxt.rdData = 32'(r.intStatus);
        timer_pkg::INT_MASK_OFS: nxt.rdData = 32'(r.intMask);
        default:
        begin
          for (int n = 0; n < timer_pkg::NUM_TIMERS; n++)
          begin
            if (wbReq.adr[7:5] == pageOf(n))
            begin
              case (wbReq.adr[4:0])
                timer_pkg::CTRL_SUB: nxt.rdData = 32'(r.cfg[n]);
                timer_pkg::CMPA_SUB: nxt.rdData = 32'(r.cmpA[n]);
                timer_pkg::CMPP_SUB: nxt.rdData = 32'(r.cmpP[n]);
                timer_pkg::COUNT_SUB: nxt.rdData = 32'(count[n]);
                timer_pkg::CAPTURE_SUB: nxt.rdData = 32'(capture[n]);
                default: nxt.rdData = 32'h0000_0000;
              endcase
            end
          end
        end
      endcase
    end
    // sticky sources, set wins over clear
    nxt.intStatus = (r.intStatus & ~w1c[3:0]) | events;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      r <= '0;
      r.pinCtrl <= timer_pkg::PIN_CTRL_RST;
      r.intMask <= timer_pkg::INT_MASK_RST;
      r.cfg <= {timer_pkg::CFG_RST, timer_pkg::CFG_RST};
    end
    else
    begin
      r <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wbRsp.ack = r.ack;
  assign wbRsp.dat = r.rdData;
  assign irq = |(r.intStatus & r.intMask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence seqStoppedRun(int n);
    cfgT[n].run && cfgT[n].clkSel == timer_pkg::CLK_RESERVED;
  endsequence

  property pStopped(int n);
    seqStoppedRun(n) ##1 seqStoppedRun(n) |=> $stable(count[n]);
  endproperty

  chk_reserved_stop: assert property (pStopped(1))
    else $error("counter moved with reserved clock select");
  chk_ext_single: assert property (extTick[1] |=> !extTick[1])
    else $error("external edge gave more than one tick");
  chk_ext_unused: assert property (
    !isExt(cfgT[0].clkSel) |-> !extClkInUse[0] && (tick[0] == 1'b0 || !extTick[0]
    || cfgT[0].clkSel != timer_pkg::CLK_RESERVED))
    else $error("external pin used while not selected");
  chk_irq_source: assert property ((events[2] && r.intMask[2]) |=> irq)
    else $error("unmasked match A event raised no interrupt");
  chk_set_wins: assert property ((events[3] && busReq && wbReq.we
    && wbReq.adr == timer_pkg::INT_STATUS_OFS) |=> r.intStatus[3])
    else $error("event lost under clear");
  chk_pin_release: assert property (!r.pinCtrl[1] |-> !timerPinOe[1])
    else $error("pin driven while assigned to other functions");
  chk_timer_mode_pin: assert property (
    cfgT[0].mode == timer_pkg::MODE_TIMER |-> !timerPinInUse[0])
    else $error("timer mode claims the pin");
  chk_bus_ack: assert property (busReq |=> r.ack ##1 !r.ack)
    else $error("ack not a single cycle after request");

endmodule : timer_block

/* File: tb/timer_pin_partner.sv */
// timer_pin_partner: board side of the timer pins, clock sources and pin loads
// assumes the bench calls its tasks from one process, after reset
module timer_pin_partner (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // timer pins
  input wire logic [1:0] timerPinOut,
  input wire logic [1:0] timerPinOe,
  output logic [1:0] timerPinIn,
  // clock sources
  output logic [1:0] extClkPin,
  output logic timebaseClk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] tbDiv;
  logic [1:0] capLevel;
  initial
  begin
    extClkPin = 2'h0;
    capLevel = 2'h0;
    timebaseClk = 1'b0;
  end
  // ----------------------------------------------------------------
  // timebase source, one edge every eight cycles
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      tbDiv <= 3'h0;
    else
      tbDiv <= tbDiv + 3'h1;
    if (!reset && tbDiv == 3'h7)
      timebaseClk <= ~timebaseClk;
  end
  // pin wire: timer drive wins, else the source level (pull-down when idle)
  assign timerPinIn = (timerPinOe & timerPinOut) | (~timerPinOe & capLevel);
  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  // n level changes on one external clock pin, four cycles apart
  task automatic edges(input int idx, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      extClkPin[idx] <= ~extClkPin[idx];
      repeat (3) @(posedge ref_clk);
    end
  endtask : edges
  task automatic drive(input int idx, input logic lvl);
    @(posedge ref_clk);
    capLevel[idx] <= lvl;
  endtask : drive
endmodule : timer_pin_partner

/* File: tb/timer_block_test.sv */
// timer_block_test: register level bench of the timer block
// assumes the board partner model and a classic wishbone master in this bench
module timer_block_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk;
  logic reset;
  timer_pkg::wb_req_t wbReq;
  timer_pkg::wb_rsp_t wbRsp;
  logic timebaseClk;
  logic irq;
  logic [1:0] extClkPin, extClkInUse, timerPinIn, timerPinOut, timerPinOe, timerPinInUse;
  int mismatches, nCompared, cycles;
  logic [31:0] rd, prev;
  timer_block i_timer_block (.ref_clk(ref_clk), .reset(reset), .wbReq(wbReq), .wbRsp(wbRsp),
    .timebaseClk(timebaseClk), .extClkPin(extClkPin), .extClkInUse(extClkInUse),
    .timerPinIn(timerPinIn), .timerPinOut(timerPinOut), .timerPinOe(timerPinOe),
    .timerPinInUse(timerPinInUse), .irq(irq));
  timer_pin_partner i_timer_pin_partner (.ref_clk(ref_clk), .reset(reset),
    .timerPinOut(timerPinOut), .timerPinOe(timerPinOe), .timerPinIn(timerPinIn),
    .extClkPin(extClkPin), .timebaseClk(timebaseClk));
  // ----------------------------------------------------------------
  // clock, timeout and tasks
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    nCompared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wbRsp.ack !== 1'b1 && n < 50);
    rd = wbRsp.dat;
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
    check({31'h0, n < 50}, 32'h1, "bus answer");
  endtask : xfer
  function automatic logic [7:0] ta(input int t, input logic [4:0] sub);
    return {(t == 1) ? timer_pkg::TIMER1_PAGE : timer_pkg::TIMER0_PAGE, sub};
  endfunction : ta
  function automatic logic [31:0] ctl(input logic [1:0] md, input logic [1:0] act,
    input logic [2:0] ck, input logic fall, input logic run);
    timer_pkg::timer_cfg_t c;
    c = '{clearOnA: 1'b1, extFalling: fall, polarity: 1'b0, outAction: act, mode: md,
      pause: 1'b0, clkSel: ck, run: run};
    return {20'h0, c};
  endfunction : ctl
  task automatic start(input int t, input logic [31:0] c);
    xfer(1'b1, ta(t, timer_pkg::CTRL_SUB), c & 32'hffe);
    xfer(1'b1, ta(t, timer_pkg::CTRL_SUB), c);
  endtask : start
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    wbReq = '0;
    reset = 1'b1;
    mismatches = 0;
    nCompared = 0;
    cycles = 0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    xfer(1'b0, timer_pkg::PIN_CTRL_OFS, 32'h0);
    check(rd, 32'h0, "pin control reset");
    xfer(1'b0, timer_pkg::INT_MASK_OFS, 32'h0);
    check({rd[31:1], irq}, 32'h0, "mask and irq reset");
    xfer(1'b1, timer_pkg::PIN_CTRL_OFS, 32'hff);
    xfer(1'b0, timer_pkg::PIN_CTRL_OFS, 32'h0);
    check(rd, 32'h3, "pin control bits");
    xfer(1'b1, 8'h1c, 32'hffff);
    xfer(1'b0, 8'h1c, 32'h0);
    check(rd, 32'h0, "unmapped read");
    for (int t = 0; t < 2; t++)
    begin
      xfer(1'b1, ta(t, timer_pkg::CMPP_SUB), 32'h1);
      xfer(1'b1, ta(t, timer_pkg::CMPA_SUB), 32'hffff);
    end
    // internal clock codes and the stopped code
    for (int k = 0; k < 6; k++)
    begin
      start(0, ctl(timer_pkg::MODE_TIMER, timer_pkg::ACT_NONE, 3'(k), 1'b0, 1'b1));
      repeat (300) @(posedge ref_clk);
      xfer(1'b0, ta(0, timer_pkg::COUNT_SUB), 32'h0);
      check({31'h0, rd[15:0] != 16'h0}, {31'h0, k != 5}, "clock select count");
      check({31'h0, extClkInUse[0]}, 32'h0, "external pin free");
    end
    // external clock, rising then falling edges
    for (int f = 0; f < 2; f++)
    begin
      prev = {31'h0, extClkPin[1]};
      start(1, ctl(timer_pkg::MODE_TIMER, timer_pkg::ACT_NONE, timer_pkg::CLK_EXT_A, f[0], 1'b1));
      check({31'h0, extClkInUse[1]}, 32'h1, "external pin taken");
      i_timer_pin_partner.edges(1, 7);
      repeat (6) @(posedge ref_clk);
      xfer(1'b0, ta(1, timer_pkg::COUNT_SUB), 32'h0);
      check(rd, (prev[0] == f[0]) ? 32'h4 : 32'h3, "external edge count");
    end
    xfer(1'b1, ta(1, timer_pkg::CTRL_SUB), 32'h0);
    check({31'h0, extClkInUse[1]}, 32'h0, "external pin released");
    // compare match output actions, interrupt
    xfer(1'b1, ta(0, timer_pkg::CMPA_SUB), 32'h5);
    for (int a = 1; a < 4; a++)
    begin
      start(0, ctl(timer_pkg::MODE_COMPARE, 2'(a), timer_pkg::CLK_SYS, 1'b0, 1'b1));
      repeat (20) @(posedge ref_clk);
      check({31'h0, timerPinOe[0]}, 32'h1, "compare pin driven");
      prev = {31'h0, timerPinOut[0]};
      repeat (6) @(posedge ref_clk);
      if (a == 3)
        check({31'h0, timerPinOut[0] == prev[0]}, 32'h0, "toggle");
      else
        check({31'h0, timerPinOut[0]}, (a == 2) ? 32'h1 : 32'h0, "set level");
      xfer(1'b0, ta(0, timer_pkg::COUNT_SUB), 32'h0);
      check({31'h0, rd <= 32'h5}, 32'h1, "cleared on match");
    end
    // p matched at count 0x100 during the full-rate run of the select loop
    xfer(1'b0, timer_pkg::INT_STATUS_OFS, 32'h0);
    check(rd & 32'h3, 32'h3, "match a and p status");
    check({31'h0, irq}, 32'h0, "masked irq");
    xfer(1'b1, timer_pkg::INT_MASK_OFS, 32'hf);
    check({31'h0, irq}, 32'h1, "unmasked irq");
    xfer(1'b1, ta(0, timer_pkg::CTRL_SUB), 32'h0);
    xfer(1'b1, timer_pkg::INT_STATUS_OFS, 32'hf);
    xfer(1'b0, timer_pkg::INT_STATUS_OFS, 32'h0);
    check({rd[31:1], irq}, 32'h0, "status cleared");
    // capture input, pwm output and pin release on timer 1
    start(1, ctl(timer_pkg::MODE_CAPTURE, timer_pkg::ACT_NONE, timer_pkg::CLK_SYS, 1'b0, 1'b1));
    check({30'h0, timerPinOe[1], timerPinInUse[1]}, 32'h1, "capture pin input");
    i_timer_pin_partner.drive(1, 1'b1);
    repeat (8) @(posedge ref_clk);
    xfer(1'b0, timer_pkg::INT_STATUS_OFS, 32'h0);
    check(rd, 32'h4, "capture event");
    check({31'h0, irq}, 32'h1, "capture irq");
    xfer(1'b0, ta(1, timer_pkg::CAPTURE_SUB), 32'h0);
    prev = rd;
    xfer(1'b0, ta(1, timer_pkg::COUNT_SUB), 32'h0);
    check({31'h0, prev != 32'h0 && prev < rd}, 32'h1, "capture value");
    xfer(1'b1, ta(1, timer_pkg::CMPA_SUB), 32'h8000);
    start(1, ctl(timer_pkg::MODE_PWM, timer_pkg::ACT_NONE, timer_pkg::CLK_SYS, 1'b0, 1'b1));
    repeat (10) @(posedge ref_clk);
    check({30'h0, timerPinOe[1], timerPinOut[1]}, 32'h3, "pwm output");
    xfer(1'b1, timer_pkg::PIN_CTRL_OFS, 32'h1);
    check({30'h0, timerPinOe[1], timerPinInUse[1]}, 32'h0, "pin returned");
    xfer(1'b1, timer_pkg::PIN_CTRL_OFS, 32'h3);
    xfer(1'b1, ta(1, timer_pkg::CTRL_SUB), ctl(timer_pkg::MODE_TIMER, 2'h0, 3'h1, 1'b0, 1'b1));
    check({30'h0, timerPinOe[1], timerPinInUse[1]}, 32'h0, "timer mode no pin");
    // compact timer has no capture, so capture mode leaves its pin alone
    xfer(1'b1, ta(0, timer_pkg::CTRL_SUB), ctl(timer_pkg::MODE_CAPTURE, 2'h0, 3'h1, 1'b0, 1'b1));
    check({30'h0, timerPinOe[0], timerPinInUse[0]}, 32'h0, "compact no capture");
    // reset in mid-run returns registers, pins and interrupt to idle
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    xfer(1'b0, timer_pkg::PIN_CTRL_OFS, 32'h0);
    check(rd, 32'h0, "pin control after reset");
    check({29'h0, timerPinOe, irq}, 32'h0, "pins and irq after reset");
    results();
  end
endmodule : timer_block_test
